// File: synth_prog_pkg.sv
// Constants shared by the serial synthesizer programmer: word layout,
// power-on words, register map, pin indices and timing figures.
// Assumes a single 40 MHz system clock and an APB register bus.
package synth_prog_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Programming word layout
  localparam int          WORD_W       = 24;     // Bits per programming word
  localparam int          CNT_W        = 5;      // Width of the bit counter
  localparam logic [4:0]  LAST_BIT     = 5'h17;  // Index of the 24th bit
  localparam int          FB_LSB       = 0;      // Feedback divisor, bits 0..6
  localparam int          DIV_W        = 7;      // Width of both divisors
  localparam int          REF_LSB      = 7;      // Reference divisor, bits 7..13
  localparam int          PRESCALE_BIT = 14;     // 1 = divide by eight
  localparam int          AUX_SEL_LO   = 15;     // Divided-output code, low
  localparam int          AUX_SEL_HI   = 16;     // Divided-output code, high
  localparam int          POST_SEL_LO  = 17;     // Post-divisor code, low
  localparam int          POST_SEL_HI  = 18;     // Post-divisor code, high
  localparam int          MAIN_EN_BIT  = 19;     // Main output enable
  localparam int          DIV_EN_BIT   = 20;     // Divided output enable
  localparam int          REF_SEL_BIT  = 22;     // 1 = reference on main output

  // Power-on words for the two variants
  localparam logic [23:0] DEFAULT_WORD_V1 = 24'hBD_097F;
  localparam logic [23:0] DEFAULT_WORD_V2 = 24'hBC_897F;

  ////////////////////////////////////////////////////////////////////////////
  // APB register map (byte addresses)
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_WORD     = 8'h00;  // Control latches
  localparam logic [7:0]  OFS_STATUS   = 8'h04;  // Receiver and output state
  localparam logic [7:0]  OFS_EVENT    = 8'h08;  // Sticky events, write one to clear
  localparam logic [7:0]  OFS_COUNT    = 8'h0C;  // Completed serial loads
  localparam int          ST_ARMED_BIT = 0;
  localparam int          ST_CNT_LSB   = 1;
  localparam int          ST_DONE_BIT  = 6;
  localparam int          ST_OE_BIT    = 7;
  localparam int          ST_SETTLE_BIT = 8;
  localparam int          EV_LOAD_BIT  = 0;
  localparam int          EV_ABORT_BIT = 1;
  localparam int          EV_W         = 2;
  localparam int          LOADS_W      = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int          SYNC_STAGES  = 3;
  localparam int          PIN_N        = 6;
  localparam int          PIN_SCLK     = 0;
  localparam int          PIN_SDATA    = 1;
  localparam int          PIN_LOAD_N   = 2;
  localparam int          PIN_OE       = 3;
  localparam int          PIN_VCO      = 4;
  localparam int          PIN_REF      = 5;
  localparam logic [5:0]  PIN_RESET    = 6'h04;  // Load enable idles high

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int          CLK_MHZ        = 40;
  localparam int          SETTLE_TIME_US = 200;
  localparam int          SETTLE_W       = 16;

  // Receiver states, Gray coded along idle, armed, done
  typedef enum logic [1:0]
  {
    RX_IDLE  = 2'b00,
    RX_ARMED = 2'b01,
    RX_DONE  = 2'b11
  } rx_state_type;

endpackage : synth_prog_pkg

// File: clk_ctrl_if.sv
// Carrier between the programmer top and its output clock generator.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface clk_ctrl_if;
  logic [1:0] post_sel;  // Post-divisor code
  logic [1:0] aux_sel;   // Divided-output code
  logic       vco_chg;   // One-cycle pulse per sampled VCO edge
  logic       main_clk;  // Post-divided VCO level
  logic       div_clk;   // Further divided level

  modport ctrl (output post_sel, output aux_sel, output vco_chg,
                input main_clk, input div_clk);
  modport gen  (input post_sel, input aux_sel, input vco_chg,
                output main_clk, output div_clk);
endinterface : clk_ctrl_if

// File: pin_sync.sv
// Three-stage synchronisers with agreement filter for asynchronous pins.
// Assumes pins may change at any time relative to ref_clk.
`timescale 1ns/100ps
module pin_sync #(
  parameter int         N       = 6,
  parameter logic [5:0] RST_VAL = 6'h00
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  // Raw pins
  input  wire logic [N-1:0] pin_in,
  // Filtered level and change pulse
  output logic      [N-1:0] level,
  output logic      [N-1:0] chg
);

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_bit
      logic [2:0] stage_r;   // stage_r[0] is read only by stage_r[1]
      logic [2:0] stage_nxt;
      logic       level_r;   // Accepted level
      logic       level_nxt;
      logic       chg_r;     // Pulse when accepted level moves
      logic       chg_nxt;

      // Shift chain; a change counts only once stages two and three agree
      always_comb
      begin
        stage_nxt = {stage_r[1:0], pin_in[g]};
        level_nxt = level_r;
        chg_nxt   = 1'b0;
        if ((stage_r[1] == stage_r[2]) && (stage_r[2] != level_r))
        begin
          level_nxt = stage_r[2];
          chg_nxt   = 1'b1;
        end
      end

      // Registers only
      always_ff @(posedge ref_clk)
      begin
        if (!nrst)
        begin
          stage_r <= {3{RST_VAL[g]}};
          level_r <= RST_VAL[g];
          chg_r   <= 1'b0;
        end
        else
        begin
          stage_r <= stage_nxt;
          level_r <= level_nxt;
          chg_r   <= chg_nxt;
        end
      end

      assign level[g] = level_r;
      assign chg[g]   = chg_r;
    end
  endgenerate

endmodule : pin_sync

// File: out_clk_gen.sv
// Post-divider and divided-output chain driven by sampled VCO edges.
// Assumes vco_chg marks each half period of the VCO as seen on ref_clk.
`timescale 1ns/100ps
module out_clk_gen (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Control and clock levels
  clk_ctrl_if.gen   cif
);

  logic [3:0] r_cur_r, r_cur_nxt;   // Post-divisor in use
  logic [2:0] pcnt_r, pcnt_nxt;     // Half periods counted for main
  logic       main_r, main_nxt;     // Post-divided level
  logic [3:0] x_cur_r, x_cur_nxt;   // Extra divisor in use
  logic [2:0] acnt_r, acnt_nxt;     // Main toggles counted for divided
  logic       div_r, div_nxt;       // Divided level

  ////////////////////////////////////////////////////////////////////////////
  // New divisors are only taken at a wrap, so no partial cycle is emitted
  always_comb
  begin
    r_cur_nxt = r_cur_r;
    pcnt_nxt  = pcnt_r;
    main_nxt  = main_r;
    x_cur_nxt = x_cur_r;
    acnt_nxt  = acnt_r;
    div_nxt   = div_r;
    if (cif.vco_chg)
    begin
      if ({1'b0, pcnt_r} == (r_cur_r - 4'h1))
      begin
        pcnt_nxt  = 3'h0;
        main_nxt  = ~main_r;
        r_cur_nxt = 4'h1 << cif.post_sel;
        if ({1'b0, acnt_r} == (x_cur_r - 4'h1))
        begin
          acnt_nxt  = 3'h0;
          div_nxt   = ~div_r;
          x_cur_nxt = 4'h1 << cif.aux_sel;
        end
        else
          acnt_nxt = acnt_r + 3'h1;
      end
      else
        pcnt_nxt = pcnt_r + 3'h1;
    end
  end

  // Registers only
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      r_cur_r <= 4'h1;
      pcnt_r  <= 3'h0;
      main_r  <= 1'b0;
      x_cur_r <= 4'h1;
      acnt_r  <= 3'h0;
      div_r   <= 1'b0;
    end
    else
    begin
      r_cur_r <= r_cur_nxt;
      pcnt_r  <= pcnt_nxt;
      main_r  <= main_nxt;
      x_cur_r <= x_cur_nxt;
      acnt_r  <= acnt_nxt;
      div_r   <= div_nxt;
    end
  end

  assign cif.main_clk = main_r;
  assign cif.div_clk  = div_r;

endmodule : out_clk_gen

// File: serial_freq_synth_programmer.sv
// Serial programming front end and control latches of a PLL synthesizer.
// Assumes the three-wire port and clock pins are asynchronous to ref_clk
// and that an APB master reaches the status and latch registers.
//
// Behaviour
// - Load enable fall arms; sample data on clock rise
// - First received bit lands at position zero
// - One word is exactly 24 shift clocks
// - On 24th edge stop and copy to latches
// - Ignore bits after 24th; host holds enable low
// - Early enable rise discards word, resets counter
// - Bits 0 to 6 are feedback divisor
// - Bits 7 to 13 are reference divisor
// - Bit 14 selects prescale one or eight
// - Bits 15,16 pick divided-output divisor
// - Bits 17,18 pick VCO post-divisor
// - Bits 19,20 enable main and divided outputs
// - Bit 22 routes reference onto main output
// - Latches reset to per-variant default word
// - Output drives only with pin and bit high
// - Settings apply at 24th edge; settle 200us
// - Main is VCO over R; divided over X
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
module serial_freq_synth_programmer #(
  parameter int VARIANT       = 1,  // Power-on word variant, 1 or 2
  parameter int SETTLE_CYCLES = synth_prog_pkg::SETTLE_TIME_US * synth_prog_pkg::CLK_MHZ
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Three-wire programming port
  input  wire logic        load_en_n,
  input  wire logic        shift_clk,
  input  wire logic        shift_data,
  // Output enable pin and clock sources
  input  wire logic        out_enable,
  input  wire logic        vco_in,
  input  wire logic        ref_in,
  // Clock outputs with their drive enables
  output logic             main_out,
  output logic             main_out_oe,
  output logic             div_out,
  output logic             div_out_oe,
  // PLL loop controls
  output logic      [6:0]  feedback_div,
  output logic      [6:0]  ref_div,
  output logic             prescale_div8
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Power-on word picked by variant
  localparam logic [23:0] DEFAULT_WORD = (VARIANT == 2) ? synth_prog_pkg::DEFAULT_WORD_V2
                                                        : synth_prog_pkg::DEFAULT_WORD_V1;
  localparam logic [15:0] SETTLE_LOAD  = 16'(SETTLE_CYCLES);

  logic [5:0]  pin_level;                       // Filtered pin levels
  logic [5:0]  pin_chg;                         // Filtered pin change pulses
  logic        sclk_rise;                       // Shift clock rising edge
  logic        load_fall;                       // Load enable falling edge
  logic        load_high;                       // Load enable deasserted

  synth_prog_pkg::rx_state_type state_r;        // Receiver state
  synth_prog_pkg::rx_state_type state_nxt;
  logic [4:0]  cnt_r, cnt_nxt;                  // Bits received so far
  logic [23:0] shift_r, shift_nxt;              // Word being assembled
  logic        load_now;                        // Word complete this cycle
  logic        abort_now;                       // Partial word dropped
  logic [23:0] new_word;                        // Word as completed

  logic [23:0] word_r, word_nxt;                // Control latches
  logic [15:0] settle_r, settle_nxt;            // Frequency settle countdown
  logic [1:0]  event_r, event_nxt;              // Sticky load and abort
  logic [15:0] loads_r, loads_nxt;              // Completed serial loads

  logic        apb_setup;                       // Setup phase of a transfer
  logic        apb_wr;                          // Write takes effect now
  logic        addr_hit;                        // Address is mapped
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;

  logic        main_r, main_nxt;                // Gated main clock level
  logic        main_oe_r, main_oe_nxt;
  logic        div_r, div_nxt;                  // Gated divided clock level
  logic        div_oe_r, div_oe_nxt;

  clk_ctrl_if  cif ();                          // Link to the divider chain

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and output clock chain

  // Every pin is asynchronous, so all share the three-stage filter
  pin_sync #(
    .N       (synth_prog_pkg::PIN_N),
    .RST_VAL (synth_prog_pkg::PIN_RESET)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pin_in  ({ref_in, vco_in, out_enable, load_en_n, shift_data, shift_clk}),
    .level   (pin_level),
    .chg     (pin_chg)
  );

  // Divider chain picks up new codes only at its own wraps
  out_clk_gen u_out_clk_gen (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .cif     (cif.gen)
  );

  // Divider codes come straight from the latches; the chain samples
  // them at wrap points, so a field never splits mid cycle
  assign cif.post_sel = word_r[synth_prog_pkg::POST_SEL_HI:synth_prog_pkg::POST_SEL_LO];
  assign cif.aux_sel  = word_r[synth_prog_pkg::AUX_SEL_HI:synth_prog_pkg::AUX_SEL_LO];
  assign cif.vco_chg  = pin_chg[synth_prog_pkg::PIN_VCO];

  // Edge qualifiers from the filtered pins
  assign sclk_rise = pin_chg[synth_prog_pkg::PIN_SCLK] & pin_level[synth_prog_pkg::PIN_SCLK];
  assign load_fall = pin_chg[synth_prog_pkg::PIN_LOAD_N] & ~pin_level[synth_prog_pkg::PIN_LOAD_N];
  assign load_high = pin_level[synth_prog_pkg::PIN_LOAD_N];

  ////////////////////////////////////////////////////////////////////////////
  // Serial receiver

  // Arms on the enable fall, shifts in on clock rises, stops at bit 24.
  // Data and clock share the same filter latency, so the data level seen
  // with the clock edge is the one that stood at the pin edge.
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    load_now  = 1'b0;
    abort_now = 1'b0;
    new_word  = {pin_level[synth_prog_pkg::PIN_SDATA], shift_r[23:1]};
    case (state_r)
      synth_prog_pkg::RX_IDLE:
      begin
        // Waiting for the enable to fall
        if (load_fall)
        begin
          state_nxt = synth_prog_pkg::RX_ARMED;
          cnt_nxt   = 5'h00;
        end
      end
      synth_prog_pkg::RX_ARMED:
      begin
        // Enable rising first wins over a coincident clock edge
        if (load_high)
        begin
          state_nxt = synth_prog_pkg::RX_IDLE;
          cnt_nxt   = 5'h00;
          abort_now = 1'b1;
        end
        else if (sclk_rise)
        begin
          // Shift right so the first bit ends at position zero
          shift_nxt = new_word;
          if (cnt_r == synth_prog_pkg::LAST_BIT)
          begin
            state_nxt = synth_prog_pkg::RX_DONE;
            load_now  = 1'b1;
          end
          else
            cnt_nxt = cnt_r + 5'h01;
        end
      end
      synth_prog_pkg::RX_DONE:
      begin
        // Further bits are dropped until the enable returns high
        if (load_high)
        begin
          state_nxt = synth_prog_pkg::RX_IDLE;
          cnt_nxt   = 5'h00;
        end
      end
      default:
      begin
        state_nxt = synth_prog_pkg::RX_IDLE;
        cnt_nxt   = 5'h00;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_r <= synth_prog_pkg::RX_IDLE;
      cnt_r   <= 5'h00;
      shift_r <= 24'h00_0000;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      shift_r <= shift_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control latches, events and settle timer

  // A serial load wins over a software write in the same cycle, because
  // the host on the pins cannot see that it lost
  always_comb
  begin
    word_nxt   = word_r;
    settle_nxt = settle_r;
    event_nxt  = event_r;
    loads_nxt  = loads_r;
    if (load_now)
      word_nxt = new_word;
    else if (apb_wr && (paddr == synth_prog_pkg::OFS_WORD))
      word_nxt = pwdata[23:0];
    // Any change restarts the settle window for the new frequency
    if (word_nxt != word_r)
      settle_nxt = SETTLE_LOAD;
    else if (settle_r != 16'h0000)
      settle_nxt = settle_r - 16'h0001;
    // Write one clears; a new event in the same cycle still sets
    if (apb_wr && (paddr == synth_prog_pkg::OFS_EVENT))
      event_nxt = event_r & ~pwdata[1:0];
    if (load_now)
    begin
      event_nxt[synth_prog_pkg::EV_LOAD_BIT] = 1'b1;
      loads_nxt = loads_r + 16'h0001;
    end
    if (abort_now)
      event_nxt[synth_prog_pkg::EV_ABORT_BIT] = 1'b1;
  end

  // Registers only; latches hold the variant word from reset
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      word_r   <= DEFAULT_WORD;
      settle_r <= 16'h0000;
      event_r  <= 2'h0;
      loads_r  <= 16'h0000;
    end
    else
    begin
      word_r   <= word_nxt;
      settle_r <= settle_nxt;
      event_r  <= event_nxt;
      loads_r  <= loads_nxt;
    end
  end

  // PLL loop fields straight from the latches
  assign feedback_div  = word_r[synth_prog_pkg::FB_LSB +: synth_prog_pkg::DIV_W];
  assign ref_div       = word_r[synth_prog_pkg::REF_LSB +: synth_prog_pkg::DIV_W];
  assign prescale_div8 = word_r[synth_prog_pkg::PRESCALE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  // Answer is prepared in the setup cycle so pready and prdata leave flops;
  // every access therefore takes exactly one access cycle
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite & pready_r;
  assign addr_hit  = (paddr == synth_prog_pkg::OFS_WORD)   ||
                     (paddr == synth_prog_pkg::OFS_STATUS) ||
                     (paddr == synth_prog_pkg::OFS_EVENT)  ||
                     (paddr == synth_prog_pkg::OFS_COUNT);

  always_comb
  begin
    pready_nxt  = apb_setup;
    pslverr_nxt = apb_setup & ~addr_hit;
    prdata_nxt  = 32'h0000_0000;
    if (apb_setup && !pwrite)
    begin
      case (paddr)
        synth_prog_pkg::OFS_WORD:
          prdata_nxt[23:0] = word_r;
        synth_prog_pkg::OFS_STATUS:
        begin
          prdata_nxt[synth_prog_pkg::ST_ARMED_BIT] = (state_r == synth_prog_pkg::RX_ARMED);
          prdata_nxt[synth_prog_pkg::ST_CNT_LSB +: 5] = cnt_r;
          prdata_nxt[synth_prog_pkg::ST_DONE_BIT]  = (state_r == synth_prog_pkg::RX_DONE);
          prdata_nxt[synth_prog_pkg::ST_OE_BIT]    = pin_level[synth_prog_pkg::PIN_OE];
          prdata_nxt[synth_prog_pkg::ST_SETTLE_BIT] = (settle_r != 16'h0000);
        end
        synth_prog_pkg::OFS_EVENT:
          prdata_nxt[1:0] = event_r;
        synth_prog_pkg::OFS_COUNT:
          prdata_nxt[15:0] = loads_r;
        default:
          prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Output gating

  // Level is forced low while not driven so the pad sees no stale value
  always_comb
  begin
    main_oe_nxt = pin_level[synth_prog_pkg::PIN_OE]
                & word_r[synth_prog_pkg::MAIN_EN_BIT];
    div_oe_nxt  = pin_level[synth_prog_pkg::PIN_OE]
                & word_r[synth_prog_pkg::DIV_EN_BIT];
    if (word_r[synth_prog_pkg::REF_SEL_BIT])
      main_nxt = pin_level[synth_prog_pkg::PIN_REF] & main_oe_nxt;
    else
      main_nxt = cif.main_clk & main_oe_nxt;
    div_nxt = cif.div_clk & div_oe_nxt;
  end

  // Registers only
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      main_r    <= 1'b0;
      main_oe_r <= 1'b0;
      div_r     <= 1'b0;
      div_oe_r  <= 1'b0;
    end
    else
    begin
      main_r    <= main_nxt;
      main_oe_r <= main_oe_nxt;
      div_r     <= div_nxt;
      div_oe_r  <= div_oe_nxt;
    end
  end

  assign main_out    = main_r;
  assign main_out_oe = main_oe_r;
  assign div_out     = div_r;
  assign div_out_oe  = div_oe_r;

endmodule : serial_freq_synth_programmer

// File: synth_prog_monitor.sv
// Port checker for the serial synthesizer programmer.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/100ps
module synth_prog_monitor (
  // Clock, reset and APB answer
  input wire logic        ref_clk, nrst, psel, penable, pready, pslverr,
  input wire logic [31:0] prdata,
  // Pins, outputs and loop fields
  input wire logic        load_en_n, out_enable, main_out, main_out_oe,
  input wire logic        div_out, div_out_oe, prescale_div8,
  input wire logic [6:0]  feedback_div, ref_div
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  // Six low samples cover the pin filter plus the output register
  a_oe_main_pin:
    assert property (!out_enable [*6] |-> !main_out_oe) else $error("main driven");
  a_oe_div_pin:
    assert property (!out_enable [*6] |-> !div_out_oe) else $error("div driven");
  a_main_quiet:
    assert property (!main_out_oe |-> !main_out) else $error("main not idle");
  a_div_quiet:
    assert property (!div_out_oe |-> !div_out) else $error("div not idle");
  // No load and no bus traffic means the loop fields must not move
  a_fields_hold:
    assert property ((load_en_n && !psel) [*8] |-> $stable({feedback_div, ref_div,
      prescale_div8})) else $error("fields moved");
  a_reset_fields:
    assert property ($rose(nrst) |-> feedback_div == 7'h7F && ref_div == 7'h12
      && !prescale_div8) else $error("bad power-on fields");
  a_ready_setup:
    assert property (psel && !penable |=> pready ##1 !pready) else $error("bad pready");
  a_idle_rdata:
    assert property (!pready |-> prdata == 32'h0000_0000) else $error("stray rdata");
  a_err_ready:
    assert property (pslverr |-> pready) else $error("lone pslverr");
  c_error: cover property (pslverr);
  c_oe_rise: cover property ($rose(main_out_oe));
  c_new_word: cover property (!$stable(feedback_div));
endmodule : synth_prog_monitor
bind serial_freq_synth_programmer synth_prog_monitor synth_prog_monitor_inst (.ref_clk,
  .nrst, .psel, .penable, .pready, .pslverr, .prdata, .load_en_n, .out_enable, .main_out,
  .main_out_oe, .div_out, .div_out_oe, .prescale_div8, .feedback_div, .ref_div);

// File: host_port_model.sv
// Host side of the three-wire programming port.
// Assumes the caller enters send just after a ref_clk edge.
`timescale 1ns/100ps
module host_port_model (
  // Pacing clock
  input wire logic ref_clk,
  // Three-wire port
  output logic     load_en_n, shift_clk, shift_data
);
  initial
  begin
    load_en_n = 1'h1;
    shift_clk = 1'h0;
    shift_data = 1'h0;
  end
  // Phases of four cycles keep the device filter satisfied
  task automatic send(input logic [23:0] w, input int n);
    load_en_n <= 1'h0;
    for (int i = 0; i < n; i++)
    begin
      repeat (4) @(posedge ref_clk);
      shift_data <= (i < 24) ? w[i] : ~w[i % 24];
      repeat (4) @(posedge ref_clk);
      shift_clk <= 1'h1;
      repeat (4) @(posedge ref_clk);
      shift_clk <= 1'h0;
    end
    repeat (4) @(posedge ref_clk);
    load_en_n <= 1'h1;
    shift_data <= ~shift_data;
  endtask : send
endmodule : host_port_model

// File: tb_top.sv
// Self-checking bench: APB reads and serial loads with expected values.
// Assumes the design package is compiled first.
`timescale 1ns/100ps
module tb_top;
  logic ref_clk, nrst, psel, penable, pwrite, out_enable, vco_in, ref_in, e;
  logic pready, pslverr, load_en_n, shift_clk, shift_data, prescale_div8;
  logic main_out, main_out_oe, div_out, div_out_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [6:0] feedback_div, ref_div;
  logic [3:0] cnt;
  int miscompares, checks_done, m, d;
  // Reserved bits 21 and 23 high, both divisors within 3 to 127, in every word
  localparam logic [23:0] W1 = 24'hAE_C987, W2 = 24'hF8_4321, W3 = 24'hB9_897F;
  serial_freq_synth_programmer #(.VARIANT(1), .SETTLE_CYCLES(20))
    serial_freq_synth_programmer_inst (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .load_en_n, .shift_clk, .shift_data, .out_enable,
    .vco_in, .ref_in, .main_out, .main_out_oe, .div_out, .div_out_oe, .feedback_div,
    .ref_div, .prescale_div8);
  host_port_model host_port_model_inst (.ref_clk, .load_en_n, .shift_clk, .shift_data);
  initial
  begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Slow sources: vco edge every 4 cycles, reference every 8
  always @(posedge ref_clk)
  begin
    cnt <= cnt + 4'h1;
    vco_in <= cnt[2];
    ref_in <= cnt[3];
  end
  task automatic chk(input string n, input logic [31:0] s, x);
    checks_done++;
    if (s !== x)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'h1;
    // Only the watchdog ends a wait that never sees pready
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // Let old divider settings wrap out, then count output edges
  task automatic toggles();
    logic pm, pd;
    repeat (128) @(posedge ref_clk);
    m = 0;
    d = 0;
    pm = main_out;
    pd = div_out;
    repeat (128)
    begin
      @(posedge ref_clk);
      m += int'(main_out !== pm);
      d += int'(div_out !== pd);
      pm = main_out;
      pd = div_out;
    end
  endtask : toggles
  task automatic load(input logic [23:0] w, input int n, input logic [23:0] x);
    host_port_model_inst.send(w, n);
    repeat (12) @(posedge ref_clk);
    apb(1'h0, synth_prog_pkg::OFS_WORD, 32'h0000_0000);
    chk("word", q, {8'h00, x});
  endtask : load
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #250000;
    miscompares++;
    report_and_stop();
  end
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata, cnt, vco_in, ref_in} = '0;
    out_enable = 1'h1;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'h1;
    apb(1'h0, synth_prog_pkg::OFS_WORD, 32'h0000_0000);
    chk("default", q, 32'h00BD_097F);
    load(W1, 26, W1);
    chk("fields", {feedback_div, ref_div, prescale_div8}, {W1[6:0], W1[13:7], W1[14]});
    chk("oe_w1", {main_out_oe, div_out_oe}, 2'h2);
    toggles();
    chk("main_r8", (m >= 3 && m <= 5), 1'h1);
    chk("div_off", d, 0);
    load(W2, 23, W1);
    load(W2, 24, W2);
    // One abort and two completed loads so far, nothing cleared
    apb(1'h0, synth_prog_pkg::OFS_EVENT, 32'h0000_0000);
    chk("events", q, 32'h0000_0003);
    apb(1'h0, synth_prog_pkg::OFS_COUNT, 32'h0000_0000);
    chk("loads", q, 32'h0000_0002);
    toggles();
    chk("ref_main", (m >= 15 && m <= 17), 1'h1);
    chk("div_x1", (d >= 31 && d <= 33), 1'h1);
    apb(1'h1, synth_prog_pkg::OFS_WORD, {8'h00, W3});
    toggles();
    chk("main_r1", (m >= 31 && m <= 33), 1'h1);
    chk("div_x8", (d >= 3 && d <= 5), 1'h1);
    apb(1'h0, 8'h40, 32'h0000_0000);
    chk("bad_err", e, 1'h1);
    chk("bad_data", q, 32'h0000_0000);
    out_enable <= 1'h0;
    repeat (8) @(posedge ref_clk);
    chk("oe_pin", {main_out_oe, div_out_oe}, 2'h0);
    report_and_stop();
  end
endmodule : tb_top
